// file: bridge_cfg_pkg.sv
// Constants shared by the bridge line-length and trim register bank.
// Assumes a single 20 MHz clock and an AXI4-Lite master with byte addresses.
// Contract
// - Out A trim bits 5:4, reset 00, four codes
// - Out B trim bits 1:0, same codes
// - Line pixels A: low byte plus high nibble
// - Single input: value is whole active line
// - Odd/even: odd pixels, to A or both
// - Left/right: left-half pixels, input A to A
// - Two-stream: pixels of stream A per line
// - B fields live only dual output, pairing 10
// - Outside two-stream, generator B uses A timing, generator A the generator-only length
// - Generator ignores sync lag values
// - Generator-only values never touch normal video
package bridge_cfg_pkg;

    // ****************************************************
    // Register indices and byte addresses
    // ****************************************************
    localparam logic [7:0] IDX_TRIM     = 8'h1B;
    localparam logic [7:0] IDX_LEN_LOW  = 8'h20;
    localparam logic [7:0] IDX_LEN_HIGH = 8'h21;
    localparam logic [7:0] IDX_CTRL     = 8'h30;
    localparam logic [7:0] IDX_STATUS   = 8'h31;
    localparam logic [7:0] ADDR_TRIM     = {IDX_TRIM[5:0], 2'b00};
    localparam logic [7:0] ADDR_LEN_LOW  = {IDX_LEN_LOW[5:0], 2'b00};
    localparam logic [7:0] ADDR_LEN_HIGH = {IDX_LEN_HIGH[5:0], 2'b00};
    localparam logic [7:0] ADDR_CTRL     = {IDX_CTRL[5:0], 2'b00};
    localparam logic [7:0] ADDR_STATUS   = {IDX_STATUS[5:0], 2'b00};

    // ****************************************************
    // Field positions and reset values
    // ****************************************************
    localparam int TRIM_A_LSB      = 4;
    localparam int TRIM_B_LSB      = 0;
    localparam int LEN_HIGH_W      = 4;
    localparam int CTRL_PAIR_LSB   = 0;
    localparam int CTRL_LR_BIT     = 2;
    localparam int CTRL_SINGLE_BIT = 3;
    localparam int CTRL_TPG_BIT    = 4;
    localparam int CTRL_W          = 5;
    localparam logic [1:0] TRIM_RESET     = 2'h0;
    localparam logic [7:0] LEN_LOW_RESET  = 8'h00;
    localparam logic [3:0] LEN_HIGH_RESET = 4'h0;
    localparam logic [4:0] CTRL_RESET     = 5'h09;

    // ****************************************************
    // Pairing codes, trim steps, bus answers
    // ****************************************************
    localparam logic [1:0] PAIR_DUAL       = 2'h0;
    localparam logic [1:0] PAIR_SINGLE     = 2'h1;
    localparam logic [1:0] PAIR_TWO_STREAM = 2'h2;
    localparam logic signed [3:0] STEP_NONE = 4'sh0;
    localparam logic signed [3:0] STEP_DN3  = -4'sh3;
    localparam logic signed [3:0] STEP_UP3  = 4'sh3;
    localparam logic signed [3:0] STEP_UP6  = 4'sh6;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        ROLE_WHOLE,
        ROLE_ODD,
        ROLE_LEFT,
        ROLE_STREAM
    } line_role_e;

endpackage

// file: cm_trim_step.sv
// Turns a two-bit common-mode trim code into a signed percent step.
// Assumes the code comes straight from a register.
module cm_trim_step
(
    input  wire logic               clk_sys,
    input  wire logic               rst_n,
    input  wire logic [1:0]         code,
    output logic signed [3:0]       step_q
);

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            step_q <= bridge_cfg_pkg::STEP_NONE;
        end
        else
        begin
            case (code)
                2'h0:    step_q <= bridge_cfg_pkg::STEP_NONE;
                2'h1:    step_q <= bridge_cfg_pkg::STEP_DN3;
                2'h2:    step_q <= bridge_cfg_pkg::STEP_UP3;
                default: step_q <= bridge_cfg_pkg::STEP_UP6;
            endcase
        end
    end

endmodule

// file: line_length_cfg.sv
// Register bank for common-mode trim and active line length of output A,
// with the mode decode that tells downstream logic how to read the length.
// Assumes an AXI4-Lite master on clk_sys; channel-B length and sync lags
// come in as inputs from their own registers.
//
// Design decision made here: the AXI4-Lite interface to the registers.
module line_length_cfg
#(
    parameter int LEN_W = 12,
    parameter int LAG_W = 12
)
(
    input  wire logic                       clk_sys,
    input  wire logic                       rst_n,

    input  wire logic [7:0]                 s_axi_awaddr,
    input  wire logic [2:0]                 s_axi_awprot,
    input  wire logic                       s_axi_awvalid,
    output logic                            s_axi_awready,
    input  wire logic [31:0]                s_axi_wdata,
    input  wire logic [3:0]                 s_axi_wstrb,
    input  wire logic                       s_axi_wvalid,
    output logic                            s_axi_wready,
    output logic [1:0]                      s_axi_bresp,
    output logic                            s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    input  wire logic [7:0]                 s_axi_araddr,
    input  wire logic [2:0]                 s_axi_arprot,
    input  wire logic                       s_axi_arvalid,
    output logic                            s_axi_arready,
    output logic [31:0]                     s_axi_rdata,
    output logic [1:0]                      s_axi_rresp,
    output logic                            s_axi_rvalid,
    input  wire logic                       s_axi_rready,

    input  wire logic [LEN_W-1:0]           line_pixels_b_in,
    input  wire logic [LAG_W-1:0]           sync_lag_a_in,
    input  wire logic [LAG_W-1:0]           sync_lag_b_in,
    input  wire logic [LEN_W-1:0]           tpg_only_pixels_in,

    output logic [1:0]                      out_a_common_mode_trim,
    output logic [1:0]                      out_b_common_mode_trim,
    output logic signed [3:0]               out_a_cm_step,
    output logic signed [3:0]               out_b_cm_step,
    output logic [LEN_W-1:0]                line_pixels_a,
    output bridge_cfg_pkg::line_role_e      line_role_a,
    output logic                            a_feeds_out_b,
    output logic                            b_fields_live,
    output logic [LEN_W-1:0]                video_pixels_b,
    output logic [LAG_W-1:0]                video_sync_lag_a,
    output logic [LAG_W-1:0]                video_sync_lag_b,
    output logic                            tpg_enable,
    output logic [LEN_W-1:0]                tpg_pixels_a,
    output logic [LEN_W-1:0]                tpg_pixels_b
);

    // ****************************************************
    // Storage
    // ****************************************************
    logic [1:0]                     trim_a_q;
    logic [1:0]                     trim_b_q;
    logic [7:0]                     len_low_q;
    logic [bridge_cfg_pkg::LEN_HIGH_W-1:0] len_high_q;
    logic [bridge_cfg_pkg::CTRL_W-1:0]     ctrl_q;

    logic                           aw_held_q;
    logic [7:0]                     aw_addr_q;
    logic                           w_held_q;
    logic [7:0]                     w_data_q;
    logic                           w_strb0_q;
    logic                           bvalid_q;
    logic [1:0]                     bresp_q;
    logic                           rvalid_q;
    logic [31:0]                    rdata_q;
    logic [1:0]                     rresp_q;

    logic                           wr_fire;
    logic                           wr_hit;
    logic                           rd_fire;
    logic [31:0]                    rd_word;
    logic                           rd_hit;

    logic                           lr_mode;
    logic                           single_out;
    logic [1:0]                     pairing;
    logic                           two_stream;
    logic                           b_live;
    logic                           a_feeds_b;
    bridge_cfg_pkg::line_role_e     role;
    logic [LEN_W-1:0]               len_a;

    assign pairing    = ctrl_q[bridge_cfg_pkg::CTRL_PAIR_LSB +: 2];
    assign lr_mode    = ctrl_q[bridge_cfg_pkg::CTRL_LR_BIT];
    assign single_out = ctrl_q[bridge_cfg_pkg::CTRL_SINGLE_BIT];
    assign two_stream = (pairing == bridge_cfg_pkg::PAIR_TWO_STREAM);
    // Length A is one value however the line is split
    assign len_a      = LEN_W'({len_high_q, len_low_q});

    // ****************************************************
    // Write channel: address and data taken in either order
    // ****************************************************
    assign s_axi_awready = !aw_held_q && !bvalid_q;
    assign s_axi_wready  = !w_held_q && !bvalid_q;
    assign wr_fire       = aw_held_q && w_held_q && !bvalid_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;

    always_comb
    begin
        case (aw_addr_q)
            bridge_cfg_pkg::ADDR_TRIM,
            bridge_cfg_pkg::ADDR_LEN_LOW,
            bridge_cfg_pkg::ADDR_LEN_HIGH,
            bridge_cfg_pkg::ADDR_CTRL,
            bridge_cfg_pkg::ADDR_STATUS:   wr_hit = 1'b1;
            default:                       wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aw_held_q <= 1'b0;
            aw_addr_q <= 8'h00;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_held_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
        end
        else if (wr_fire)
        begin
            aw_held_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            w_held_q  <= 1'b0;
            w_data_q  <= 8'h00;
            w_strb0_q <= 1'b0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_held_q  <= 1'b1;
            w_data_q  <= s_axi_wdata[7:0];
            w_strb0_q <= s_axi_wstrb[0];
        end
        else if (wr_fire)
        begin
            w_held_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bvalid_q <= 1'b0;
            bresp_q  <= bridge_cfg_pkg::RESP_OKAY;
        end
        else if (wr_fire)
        begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_hit ? bridge_cfg_pkg::RESP_OKAY : bridge_cfg_pkg::RESP_SLVERR;
        end
        else if (s_axi_bready)
        begin
            bvalid_q <= 1'b0;
        end
    end

    // ****************************************************
    // Register writes: only byte lane 0 carries data
    // ****************************************************
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            trim_a_q <= bridge_cfg_pkg::TRIM_RESET;
            trim_b_q <= bridge_cfg_pkg::TRIM_RESET;
        end
        else if (wr_fire && w_strb0_q && aw_addr_q == bridge_cfg_pkg::ADDR_TRIM)
        begin
            // Bits 7:6 and 3:2 are dropped
            trim_a_q <= w_data_q[bridge_cfg_pkg::TRIM_A_LSB +: 2];
            trim_b_q <= w_data_q[bridge_cfg_pkg::TRIM_B_LSB +: 2];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            len_low_q <= bridge_cfg_pkg::LEN_LOW_RESET;
        end
        else if (wr_fire && w_strb0_q && aw_addr_q == bridge_cfg_pkg::ADDR_LEN_LOW)
        begin
            len_low_q <= w_data_q;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            len_high_q <= bridge_cfg_pkg::LEN_HIGH_RESET;
        end
        else if (wr_fire && w_strb0_q && aw_addr_q == bridge_cfg_pkg::ADDR_LEN_HIGH)
        begin
            len_high_q <= w_data_q[bridge_cfg_pkg::LEN_HIGH_W-1:0];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_q <= bridge_cfg_pkg::CTRL_RESET;
        end
        else if (wr_fire && w_strb0_q && aw_addr_q == bridge_cfg_pkg::ADDR_CTRL)
        begin
            ctrl_q <= w_data_q[bridge_cfg_pkg::CTRL_W-1:0];
        end
    end

    // ****************************************************
    // Read channel
    // ****************************************************
    assign s_axi_arready = !rvalid_q;
    assign rd_fire       = s_axi_arvalid && s_axi_arready;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    // Reserved bits and upper bytes always read as zero
    always_comb
    begin
        rd_word = 32'h0000_0000;
        rd_hit  = 1'b1;
        case (s_axi_araddr)
            bridge_cfg_pkg::ADDR_TRIM:
            begin
                rd_word[bridge_cfg_pkg::TRIM_A_LSB +: 2] = trim_a_q;
                rd_word[bridge_cfg_pkg::TRIM_B_LSB +: 2] = trim_b_q;
            end
            bridge_cfg_pkg::ADDR_LEN_LOW:  rd_word[7:0] = len_low_q;
            bridge_cfg_pkg::ADDR_LEN_HIGH: rd_word[bridge_cfg_pkg::LEN_HIGH_W-1:0] = len_high_q;
            bridge_cfg_pkg::ADDR_CTRL:     rd_word[bridge_cfg_pkg::CTRL_W-1:0] = ctrl_q;
            bridge_cfg_pkg::ADDR_STATUS:
            begin
                rd_word[1:0] = role;
                rd_word[2]   = a_feeds_b;
                rd_word[3]   = b_live;
                rd_word[4]   = tpg_enable;
            end
            default:                       rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= bridge_cfg_pkg::RESP_OKAY;
        end
        else if (rd_fire)
        begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_word;
            rresp_q  <= rd_hit ? bridge_cfg_pkg::RESP_OKAY : bridge_cfg_pkg::RESP_SLVERR;
        end
        else if (s_axi_rready)
        begin
            rvalid_q <= 1'b0;
        end
    end

    // ****************************************************
    // Trim decode and mode decode
    // ****************************************************
    logic [1:0]        trim_code [2];
    logic signed [3:0] trim_step [2];

    assign trim_code[0] = trim_a_q;
    assign trim_code[1] = trim_b_q;

    for (genvar ch = 0; ch < 2; ch++)
    begin : g_trim
        cm_trim_step u_step
        (
            .clk_sys (clk_sys),
            .rst_n   (rst_n),
            .code    (trim_code[ch]),
            .step_q  (trim_step[ch])
        );
    end

    assign out_a_common_mode_trim = trim_a_q;
    assign out_b_common_mode_trim = trim_b_q;
    assign out_a_cm_step          = trim_step[0];
    assign out_b_cm_step          = trim_step[1];

    line_mode_decode u_mode
    (
        .clk_sys     (clk_sys),
        .rst_n       (rst_n),
        .pairing     (pairing),
        .left_right  (lr_mode),
        .single_out  (single_out),
        .role_q      (role),
        .a_feeds_b_q (a_feeds_b),
        .b_live_q    (b_live)
    );

    assign line_role_a   = role;
    assign a_feeds_out_b = a_feeds_b;
    assign b_fields_live = b_live;
    assign tpg_enable    = ctrl_q[bridge_cfg_pkg::CTRL_TPG_BIT];
    assign line_pixels_a = len_a;

    // ****************************************************
    // Normal video and test pattern timing
    // ****************************************************
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            video_pixels_b   <= '0;
            video_sync_lag_a <= '0;
            video_sync_lag_b <= '0;
        end
        else
        begin
            // Channel-B length reaches video only in two-stream dual output
            video_pixels_b   <= b_live ? line_pixels_b_in : '0;
            // Lags steer normal video; test-only values never arrive here
            video_sync_lag_a <= sync_lag_a_in;
            video_sync_lag_b <= b_live ? sync_lag_b_in : '0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tpg_pixels_a <= '0;
            tpg_pixels_b <= '0;
        end
        else if (!tpg_enable)
        begin
            tpg_pixels_a <= '0;
            tpg_pixels_b <= '0;
        end
        else if (b_live)
        begin
            tpg_pixels_a <= len_a;
            tpg_pixels_b <= line_pixels_b_in;
        end
        else
        begin
            // Generator B follows channel A; generator A does only in two-stream, else tpg_only_pixels_in; no lag is applied
            tpg_pixels_a <= two_stream ? len_a : tpg_only_pixels_in;
            tpg_pixels_b <= len_a;
        end
    end

endmodule

// file: line_length_cfg_checker.sv
// Concurrent checks on the line-length and trim register bank.
// Assumes binding to line_length_cfg; sees only its ports.
module line_length_cfg_checker
#(
    parameter int LEN_W = 12,
    parameter int LAG_W = 12
)
(
    input wire logic                        clk_sys,
    input wire logic                        rst_n,
    input wire logic                        s_axi_awvalid,
    input wire logic                        s_axi_awready,
    input wire logic                        s_axi_wvalid,
    input wire logic                        s_axi_wready,
    input wire logic                        s_axi_bvalid,
    input wire logic                        s_axi_arvalid,
    input wire logic                        s_axi_arready,
    input wire logic [31:0]                 s_axi_rdata,
    input wire logic                        s_axi_rvalid,
    input wire logic                        s_axi_rready,
    input wire logic [1:0]                  out_a_common_mode_trim,
    input wire logic [1:0]                  out_b_common_mode_trim,
    input wire logic signed [3:0]           out_a_cm_step,
    input wire logic signed [3:0]           out_b_cm_step,
    input wire bridge_cfg_pkg::line_role_e  line_role_a,
    input wire logic                        a_feeds_out_b,
    input wire logic                        b_fields_live,
    input wire logic [LEN_W-1:0]            line_pixels_b_in,
    input wire logic [LEN_W-1:0]            video_pixels_b,
    input wire logic [LAG_W-1:0]            sync_lag_a_in,
    input wire logic [LAG_W-1:0]            video_sync_lag_a,
    input wire logic                        tpg_enable,
    input wire logic [LEN_W-1:0]            tpg_pixels_a
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    function automatic logic signed [3:0] step_of(input logic [1:0] c);
        return (c == 2'h0) ? bridge_cfg_pkg::STEP_NONE : (c == 2'h1) ? bridge_cfg_pkg::STEP_DN3 :
               (c == 2'h2) ? bridge_cfg_pkg::STEP_UP3 : bridge_cfg_pkg::STEP_UP6;
    endfunction
    sequence wr_taken; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
    sequence rd_taken; s_axi_arvalid && s_axi_arready; endsequence
    sequence live_two; b_fields_live && $past(b_fields_live); endsequence
    AST_STEP_A: assert property (1'b1 |=> out_a_cm_step == step_of($past(out_a_common_mode_trim)))
        else $error("trim step A wrong");
    AST_STEP_B: assert property (1'b1 |=> out_b_cm_step == step_of($past(out_b_common_mode_trim)))
        else $error("trim step B wrong");
    AST_WR_RESP: assert property (wr_taken |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    AST_RD_RESP: assert property (rd_taken |=> s_axi_rvalid)
        else $error("read answer late");
    AST_RD_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    AST_RD_RSVD: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("upper read bits set");
    AST_LIVE_ROLE: assert property (b_fields_live |-> line_role_a == bridge_cfg_pkg::ROLE_STREAM)
        else $error("B fields live outside two-stream");
    AST_FEED_ROLE: assert property (a_feeds_out_b |-> line_role_a == bridge_cfg_pkg::ROLE_ODD)
        else $error("A feeds B outside odd/even");
    AST_PIX_B_ON: assert property (live_two ##0 $stable(line_pixels_b_in) |-> video_pixels_b == line_pixels_b_in)
        else $error("B length not passed");
    AST_PIX_B_OFF: assert property (!b_fields_live && !$past(b_fields_live) |-> video_pixels_b == '0)
        else $error("B length leaks");
    AST_LAG_A: assert property (1'b1 |=> video_sync_lag_a == $past(sync_lag_a_in))
        else $error("sync lag A wrong");
    AST_TPG_OFF: assert property (!tpg_enable && !$past(tpg_enable) |-> tpg_pixels_a == '0)
        else $error("generator length while off");
endmodule

// file: line_length_cfg_tb_top.sv
// Self-checking bench for the line-length and trim register bank.
// Assumes a 50 ns clock and AXI4-Lite byte addresses.
module line_length_cfg_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_sys, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic        a_feeds_out_b, b_fields_live, tpg_enable;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, out_a_common_mode_trim, out_b_common_mode_trim;
    logic [11:0] line_pixels_b_in, sync_lag_a_in, sync_lag_b_in, tpg_only_pixels_in, line_pixels_a;
    logic [11:0] video_pixels_b, video_sync_lag_a, video_sync_lag_b, tpg_pixels_a, tpg_pixels_b;
    logic signed [3:0] out_a_cm_step, out_b_cm_step;
    bridge_cfg_pkg::line_role_e line_role_a;
    int          fails, n_checks;
    localparam logic [1:0] OK = bridge_cfg_pkg::RESP_OKAY, ERR = bridge_cfg_pkg::RESP_SLVERR;
    localparam logic [7:0] TRIM = bridge_cfg_pkg::ADDR_TRIM, LO = bridge_cfg_pkg::ADDR_LEN_LOW;
    localparam logic [7:0] HI = bridge_cfg_pkg::ADDR_LEN_HIGH, CTL = bridge_cfg_pkg::ADDR_CTRL;

    line_length_cfg i_dut (.*, .s_axi_awprot(3'h0), .s_axi_arprot(3'h0));

    // ****************
    // Compare, verdict and bus tasks
    // ****************
    task check(input logic [31:0] got, logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task give_verdict;
        if (fails == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task wr(input logic [7:0] a, logic [31:0] d, logic [3:0] s, logic [1:0] er);
        int n;
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 20 && !s_axi_bvalid; n++)
        begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
        if (n == 20) fails++;
        if (n == 20) give_verdict;
        check(s_axi_bresp, er);
    endtask
    task rd(input logic [7:0] a, logic [31:0] ed, logic [1:0] er);
        int n;
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 20 && !s_axi_rvalid; n++)
        begin
            @(posedge clk_sys);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
        if (n == 20) fails++;
        if (n == 20) give_verdict;
        check(s_axi_rdata, ed);
        check(s_axi_rresp, er);
    endtask

    // ****************
    // Scenarios
    // ****************
    task t_reset;
        rd(TRIM, 32'h0, OK);
        rd(LO, 32'h0, OK);
        rd(HI, 32'h0, OK);
        rd(CTL, 32'h09, OK);
        check(line_pixels_a, 32'h0);
    endtask
    task automatic t_trim;
        logic signed [3:0] st [4] = '{bridge_cfg_pkg::STEP_NONE, bridge_cfg_pkg::STEP_DN3,
            bridge_cfg_pkg::STEP_UP3, bridge_cfg_pkg::STEP_UP6};
        for (int i = 0; i < 4; i++)
        begin
            wr(TRIM, {24'hFFFFFF, 2'h3, 2'(i), 2'h3, 2'(3 - i)}, 4'h1, OK);
            rd(TRIM, {26'h0, 2'(i), 2'h0, 2'(3 - i)}, OK);
            check(out_a_common_mode_trim, 32'(i));
            check(out_b_common_mode_trim, 32'(3 - i));
            check(out_a_cm_step, st[i]);
            check(out_b_cm_step, st[3 - i]);
        end
    endtask
    task t_len;
        wr(LO, 32'hFFFFFFA5, 4'h1, OK);
        wr(HI, 32'hFC, 4'h1, OK);
        wr(LO, 32'h11, 4'h0, OK);
        rd(HI, 32'h0C, OK);
        rd(LO, 32'hA5, OK);
        check(line_pixels_a, 32'hCA5);
        wr(8'h10, 32'h1, 4'h1, ERR);
        rd(8'h10, 32'h0, ERR);
    endtask
    task automatic t_modes;
        logic [7:0] mc [7] = '{8'h09, 8'h00, 8'h08, 8'h03, 8'h04, 8'h02, 8'h0A};
        logic [1:0] rl [7] = '{2'h0, 2'h1, 2'h1, 2'h1, 2'h2, 2'h3, 2'h3};
        logic [6:0] fd = 7'h0A, lv = 7'h20;
        for (int i = 0; i < 7; i++)
        begin
            wr(CTL, {24'h0, mc[i]}, 4'h1, OK);
            repeat (2) @(posedge clk_sys);
            check(line_role_a, rl[i]);
            check(a_feeds_out_b, fd[i]);
            check(b_fields_live, lv[i]);
            check(video_pixels_b, lv[i] ? 32'h3C7 : 32'h0);
            check(video_sync_lag_b, lv[i] ? 32'h5A1 : 32'h0);
            rd(bridge_cfg_pkg::ADDR_STATUS, {27'h0, mc[i][4], lv[i], fd[i], rl[i]}, OK);
        end
    endtask
    task t_tpg;
        wr(CTL, 32'h12, 4'h1, OK);
        repeat (2) @(posedge clk_sys);
        check(tpg_enable, 32'h1);
        check(tpg_pixels_a, 32'hCA5);
        check(tpg_pixels_b, 32'h3C7);
        wr(CTL, 32'h10, 4'h1, OK);
        sync_lag_a_in <= 12'h7E1;
        tpg_only_pixels_in <= 12'h155;
        repeat (2) @(posedge clk_sys);
        check(tpg_pixels_a, 32'h155);
        check(tpg_pixels_b, 32'hCA5);
        check(video_sync_lag_a, 32'h7E1);
        check(line_pixels_a, 32'hCA5);
        check(video_pixels_b, 32'h0);
        wr(CTL, 32'h00, 4'h1, OK);
        repeat (2) @(posedge clk_sys);
        check(tpg_pixels_a, 32'h0);
        check(tpg_pixels_b, 32'h0);
    endtask

    initial
    begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    initial
    begin
        {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        line_pixels_b_in = 12'h3C7;
        sync_lag_a_in = 12'h2B4;
        sync_lag_b_in = 12'h5A1;
        tpg_only_pixels_in = 12'h0F3;
        fails = 0;
        n_checks = 0;
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_reset;
        t_trim;
        t_len;
        t_modes;
        t_tpg;
        give_verdict;
    end
endmodule

bind line_length_cfg line_length_cfg_checker #(.LEN_W(LEN_W), .LAG_W(LAG_W)) i_chk (.*);

// file: line_mode_decode.sv
// Decodes input pairing and output selection into the role of line value A.
// Assumes control bits come from registers in the same clock domain.
module line_mode_decode
(
    input  wire logic                       clk_sys,
    input  wire logic                       rst_n,
    input  wire logic [1:0]                 pairing,
    input  wire logic                       left_right,
    input  wire logic                       single_out,
    output bridge_cfg_pkg::line_role_e      role_q,
    output logic                            a_feeds_b_q,
    output logic                            b_live_q
);

    bridge_cfg_pkg::line_role_e role_d;

    always_comb
    begin
        case (pairing)
            bridge_cfg_pkg::PAIR_SINGLE:     role_d = bridge_cfg_pkg::ROLE_WHOLE;
            bridge_cfg_pkg::PAIR_TWO_STREAM: role_d = bridge_cfg_pkg::ROLE_STREAM;
            default:
            begin
                role_d = left_right ? bridge_cfg_pkg::ROLE_LEFT
                                    : bridge_cfg_pkg::ROLE_ODD;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            role_q      <= bridge_cfg_pkg::ROLE_WHOLE;
            a_feeds_b_q <= 1'b0;
            b_live_q    <= 1'b0;
        end
        else
        begin
            role_q      <= role_d;
            // Odd pixels reach both outputs only with dual output selected
            a_feeds_b_q <= (role_d == bridge_cfg_pkg::ROLE_ODD) && !single_out;
            b_live_q    <= !single_out && (pairing == bridge_cfg_pkg::PAIR_TWO_STREAM);
        end
    end

endmodule
